// ===== tcas_pkg.sv
package tcas_pkg;

    // ----------------------------------------------------------------
    // Command field layout
    // ----------------------------------------------------------------
    localparam int BIT_ID_ASSIGN = 31;
    localparam int BIT_EXTENDED = 30;
    localparam int BIT_CHAIN_SELECT = 29;
    localparam int DEV_ID_HI = 28;
    localparam int DEV_ID_LO = 24;
    localparam int BIT_READ = 23;
    localparam int REG_ID_HI = 22;
    localparam int REG_ID_LO = 16;
    localparam int DATA_HI = 15;
    localparam int DATA_LO = 8;
    localparam int AUDIO_HI = 31;
    localparam int AUDIO_LO = 8;

    localparam logic [4:0] ID_BROADCAST = 5'h1f;
    localparam logic [4:0] ID_NONE = 5'h00;
    localparam logic [4:0] ID_MAX = 5'h1e;

    // ----------------------------------------------------------------
    // Bit positions within a field, counted MSB = 31
    // ----------------------------------------------------------------
    localparam logic [4:0] FIELD_FIRST_BIT = 5'h1f;
    localparam logic [4:0] FIELD_LAST_BIT = 5'h00;
    localparam logic [4:0] RD_ENABLE_BIT = 5'h11;
    localparam logic [4:0] RD_FETCH_BIT = 5'h10;
    localparam logic [4:0] RD_LAST_DATA_BIT = 5'h09;
    localparam logic [4:0] RD_RELEASE_BIT = 5'h08;
    localparam logic [4:0] WR_DECODE_BIT = 5'h08;

    // ----------------------------------------------------------------
    // Frame sync detection
    // ----------------------------------------------------------------
    localparam logic [3:0] FS_TDM_WIDTH = 4'h2;
    localparam logic [1:0] FS_TDM_FRAMES = 2'h2;

    // ----------------------------------------------------------------
    // Mode registers and APB map
    // ----------------------------------------------------------------
    localparam logic [3:0] MODE_REG_GROUP = 4'h2;
    localparam logic [2:0] CHAN_REG_IDX = 3'h3;
    localparam logic [2:0] DEVID_REG_IDX = 3'h7;
    localparam int CHAN_DISABLE_BIT = 0;
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [6:0] ADDR_MODE_PAGE = 7'h02;
    localparam int ST_MODE_BIT = 5;
    localparam int ST_VALID_BIT = 6;

    typedef enum logic [2:0] {
        FLD_IDLE = 3'b000,
        FLD_CMD = 3'b001,
        FLD_EXT = 3'b010,
        FLD_AUDIO = 3'b011,
        FLD_ID = 3'b100
    } tcas_field_t;

    typedef enum logic [1:0] {
        OWN_WAIT = 2'b00,
        OWN_FIRST = 2'b01,
        OWN_SECOND = 2'b10,
        OWN_DONE = 2'b11
    } tcas_own_t;

endpackage

// ===== tcas_slave.sv

`timescale 1ns/1ps
`default_nettype none

module tcas_slave
    import tcas_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic bit_clock, // Link bit clock pin.
    input wire logic frame_sync, // Link frame sync pin.
    input wire logic frame_serial_in, // Link command and audio data pin.
    input wire logic chain_token_in, // Daisy chain token from previous device.
    output logic chain_token_out, // Daisy chain token to next device.
    output logic readback_out, // Readback data pin value.
    output logic readback_oe_n, // Readback driver enable, active low.
    output logic [23:0] audio_left, // First own audio channel.
    output logic [23:0] audio_right, // Second own audio channel.
    output logic audio_valid, // Pulse when both channels were received.
    output logic tdm_mode // Multiplexed mode is active.
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic bck_s, fs_s, din_s, tok_s;
    logic bck_d, rise, fall;
    assign pin_raw = {bit_clock, frame_sync, frame_serial_in, chain_token_in};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    assign {bck_s, fs_s, din_s, tok_s} = pin_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_d <= 1'b0;
        end else begin
            bck_d <= bck_s;
        end
    end

    assign rise = bck_s & ~bck_d;
    assign fall = ~bck_s & bck_d;

    // ----------------------------------------------------------------
    // Frame sync and mode detection
    // ----------------------------------------------------------------
    logic fs_prev, frame_ok, frame_start, fs_end;
    logic [3:0] fs_width;
    logic [1:0] tdm_frames;
    assign frame_start = rise & fs_s & ~fs_prev;
    assign fs_end = rise & ~fs_s & fs_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_prev <= 1'b0;
            fs_width <= 4'h0;
            tdm_frames <= 2'h0;
            tdm_mode <= 1'b0;
            frame_ok <= 1'b0;
        end else begin
            tdm_mode <= (tdm_frames == FS_TDM_FRAMES);
            if (rise) begin
                fs_prev <= fs_s;
            end
            if (frame_start) begin
                fs_width <= 4'h1;
                frame_ok <= tdm_mode;
            end else if (rise && fs_s && fs_width != 4'hf) begin
                fs_width <= fs_width + 4'h1;
            end
            // A wide sync pulse, as in ordinary stereo framing, drops the mode at once.
            if (fs_end) begin
                if (fs_width != FS_TDM_WIDTH) begin
                    tdm_frames <= 2'h0;
                end else if (tdm_frames != FS_TDM_FRAMES) begin
                    tdm_frames <= tdm_frames + 2'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Field tracking
    // ----------------------------------------------------------------
    tcas_field_t fld;
    logic [4:0] fbit, this_bit;
    logic [31:0] sh, word, cw;
    assign this_bit = (frame_start || fbit == FIELD_LAST_BIT) ? FIELD_FIRST_BIT :
                      fbit - 5'h01;
    assign word = {sh[30:0], din_s};
    assign cw = word << this_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fld <= FLD_IDLE;
            fbit <= FIELD_LAST_BIT;
            sh <= 32'h0;
        end else if (rise) begin
            sh <= word;
            fbit <= this_bit;
            if (frame_start) begin
                fld <= FLD_CMD;
            end else if (this_bit == FIELD_LAST_BIT) begin
                case (fld)
                    FLD_CMD: begin
                        if (word[BIT_ID_ASSIGN]) begin
                            fld <= FLD_ID;
                        end else if (word[BIT_EXTENDED]) begin
                            fld <= FLD_EXT;
                        end else begin
                            fld <= FLD_AUDIO;
                        end
                    end
                    FLD_EXT: fld <= word[BIT_EXTENDED] ? FLD_EXT : FLD_IDLE;
                    default: fld <= fld;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [7:0] mode_reg [0:7];
    logic id_valid, addressed, own_id, wr_hit, rd_hit, chan_en;
    logic [4:0] dev_id, rx_id;
    logic [6:0] rx_reg;
    assign dev_id = mode_reg[DEVID_REG_IDX][4:0];
    assign chan_en = ~mode_reg[CHAN_REG_IDX][CHAN_DISABLE_BIT];
    assign rx_id = cw[DEV_ID_HI:DEV_ID_LO];
    assign rx_reg = cw[REG_ID_HI:REG_ID_LO];
    assign own_id = id_valid && rx_id == dev_id;
    // Bit 31 is reserved in extended fields, so it only gates the first field.
    assign addressed = frame_ok && (fld == FLD_CMD || fld == FLD_EXT)
                       && !cw[BIT_CHAIN_SELECT]
                       && (fld == FLD_EXT || !cw[BIT_ID_ASSIGN])
                       && rx_id != ID_NONE;
    assign wr_hit = rise && this_bit == WR_DECODE_BIT && addressed && !cw[BIT_READ]
                    && (own_id || rx_id == ID_BROADCAST);
    assign rd_hit = rise && this_bit == RD_ENABLE_BIT && addressed && cw[BIT_READ]
                    && own_id;

    function automatic logic [7:0] reg_lookup(input logic [6:0] id);
        reg_lookup = (id[6:3] == MODE_REG_GROUP) ? mode_reg[id[2:0]] : 8'h00;
    endfunction

    // ----------------------------------------------------------------
    // Identifier assignment
    // ----------------------------------------------------------------
    logic [4:0] id_slot;
    logic id_seen, id_take, id_load;
    // The first slot in which the token is seen high fixes this device's position.
    assign id_take = rise && !frame_start && fld == FLD_ID && frame_ok && !id_seen && tok_s;
    assign id_load = id_take && id_slot < ID_MAX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_slot <= 5'h00;
            id_seen <= 1'b0;
            id_valid <= 1'b0;
        end else begin
            if (frame_start) begin
                id_slot <= 5'h00;
                id_seen <= 1'b0;
            end else if (rise && fld == FLD_ID) begin
                if (id_slot != 5'h1f) begin
                    id_slot <= id_slot + 5'h01;
                end
                if (id_take) begin
                    id_seen <= 1'b1;
                end
            end
            if (id_load) begin
                id_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    logic apb_wr, mode_hit;
    logic [2:0] apb_idx;
    assign mode_hit = paddr[11:5] == ADDR_MODE_PAGE && paddr[1:0] == 2'h0;
    assign apb_idx = paddr[4:2];
    assign apb_wr = psel && penable && pready && pwrite;

    // Bus writes win over a link write landing in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                mode_reg[i] <= MODE_REG_RESET;
            end
        end else begin
            if (apb_wr && mode_hit && apb_idx != DEVID_REG_IDX) begin
                mode_reg[apb_idx] <= pwdata[7:0];
            end else if (wr_hit && rx_reg[6:3] == MODE_REG_GROUP
                         && rx_reg[2:0] != DEVID_REG_IDX) begin
                mode_reg[rx_reg[2:0]] <= cw[DATA_HI:DATA_LO];
            end
            if (id_load) begin
                mode_reg[DEVID_REG_IDX] <= {3'h0, id_slot + 5'h01};
            end
        end
    end

    // ----------------------------------------------------------------
    // Readback
    // ----------------------------------------------------------------
    logic rd_active;
    logic [7:0] rd_shift;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_active <= 1'b0;
            rd_shift <= 8'h00;
            readback_out <= 1'b0;
            readback_oe_n <= 1'b1;
        end else if (frame_start) begin
            rd_active <= 1'b0;
            readback_oe_n <= 1'b1;
        end else if (rise) begin
            if (rd_hit) begin
                rd_active <= 1'b1;
            end
            if (rd_active && this_bit == RD_FETCH_BIT) begin
                rd_shift <= reg_lookup(rx_reg);
            end
        end else if (fall && rd_active) begin
            if (fbit == RD_ENABLE_BIT) begin
                readback_oe_n <= 1'b0;
                readback_out <= 1'b0;
            end else if (fbit <= RD_FETCH_BIT && fbit >= RD_LAST_DATA_BIT) begin
                readback_out <= rd_shift[7];
                rd_shift <= {rd_shift[6:0], 1'b0};
            end else if (fbit == RD_RELEASE_BIT) begin
                readback_oe_n <= 1'b1;
                readback_out <= 1'b0;
                rd_active <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Audio slots and chain token
    // ----------------------------------------------------------------
    tcas_own_t own;
    logic pending, audio_bound;
    assign audio_bound = rise && !frame_start && this_bit == FIELD_FIRST_BIT && fld == FLD_AUDIO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own <= OWN_WAIT;
            pending <= 1'b0;
        end else if (frame_start) begin
            own <= OWN_WAIT;
            pending <= 1'b0;
        end else if (audio_bound) begin
            pending <= 1'b0;
            case (own)
                OWN_WAIT: begin
                    if ((pending || tok_s) && chan_en && frame_ok) begin
                        own <= OWN_FIRST;
                    end
                end
                OWN_FIRST: own <= OWN_SECOND;
                OWN_SECOND: own <= OWN_DONE;
                default: own <= own;
            endcase
        end else if (rise && tok_s) begin
            pending <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            audio_left <= 24'h0;
            audio_right <= 24'h0;
            audio_valid <= 1'b0;
        end else begin
            audio_valid <= 1'b0;
            if (rise && this_bit == FIELD_LAST_BIT && fld == FLD_AUDIO) begin
                if (own == OWN_FIRST) begin
                    audio_left <= word[AUDIO_HI:AUDIO_LO];
                end else if (own == OWN_SECOND) begin
                    audio_right <= word[AUDIO_HI:AUDIO_LO];
                    audio_valid <= 1'b1;
                end
            end
        end
    end

    // The pass-through adds the synchroniser delay to the token, which the
    // next device absorbs because it samples only on the following bit clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_token_out <= 1'b0;
        end else if (frame_start) begin
            chain_token_out <= 1'b0;
        end else if (fld == FLD_ID) begin
            if (id_take) begin
                chain_token_out <= 1'b1;
            end
        end else if (!chan_en) begin
            chain_token_out <= tok_s;
        end else begin
            chain_token_out <= (own == OWN_SECOND);
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic [31:0] next_prdata;
    logic next_pslverr;
    always_comb begin
        next_prdata = 32'h0;
        next_pslverr = 1'b0;
        if (paddr == ADDR_STATUS) begin
            next_prdata[4:0] = dev_id;
            next_prdata[ST_MODE_BIT] = tdm_mode;
            next_prdata[ST_VALID_BIT] = id_valid;
        end else if (mode_hit) begin
            next_prdata[7:0] = mode_reg[apb_idx];
        end else begin
            next_pslverr = 1'b1;
        end
    end

    // One wait state: ready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h0 : next_prdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // tcas_slave

`default_nettype wire

// ===== tcas_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tcas_assertions (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic bit_clock, // Link bit clock.
    input wire logic frame_sync, // Link frame sync.
    input wire logic readback_oe_n, // Readback enable, active low.
    input wire logic audio_valid, // Audio pair received.
    input wire logic tdm_mode // Multiplexed mode.
);
    // ----------------------------------------------------------------
    // Readback window
    // ----------------------------------------------------------------
    // Raw pin falls are counted; the design's own sync delay is shorter than half a bit.
    logic bc_q;
    logic [4:0] fall_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bc_q <= 1'b0;
            fall_cnt <= 5'h00;
        end else begin
            bc_q <= bit_clock;
            if (readback_oe_n) fall_cnt <= 5'h00;
            else if (bc_q && !bit_clock) fall_cnt <= fall_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    ready_latency_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    oe_window_a: assert property ($rose(readback_oe_n) |-> fall_cnt == 5'h09)
        else $error("readback window not nine bits");
    audio_pulse_a: assert property (audio_valid |=> !audio_valid)
        else $error("audio_valid too long");
    audio_mode_a: assert property (audio_valid |-> tdm_mode)
        else $error("audio outside mode");
    mode_rise_a: assert property ($rose(tdm_mode) |-> !frame_sync)
        else $error("mode rose inside sync pulse");

    cover property ($rose(tdm_mode));
    cover property ($fell(readback_oe_n));
    cover property (audio_valid);
    cover property (pslverr);
endmodule // tcas_assertions

bind tcas_slave tcas_assertions chk_u (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .bit_clock, .frame_sync, .readback_oe_n, .audio_valid, .tdm_mode);

`default_nettype wire

// ===== tcas_host.sv
`timescale 1ns/1ps
`default_nettype none

module tcas_host (
    input wire logic pclk, // Clock.
    output logic bit_clock, // Link bit clock.
    output logic frame_sync, // Link frame sync.
    output logic frame_serial_in, // Link data.
    output logic chain_token_in, // Token from the device before.
    input wire logic chain_token_out, // Token from the device.
    input wire logic readback_out, // Readback value.
    input wire logic readback_oe_n, // Readback enable, active low.
    output logic [31:0] cap, // Readback bits of the first field.
    output logic [2:0] tokf // Token seen high per field.
);
    // ----------------------------------------------------------------
    // Frame source
    // ----------------------------------------------------------------
    logic rb_last = 1'b0;
    logic rb_line;
    // A released line must not show the last driven bit.
    assign rb_line = readback_oe_n ? ~rb_last : readback_out;
    always @(posedge pclk) if (!readback_oe_n) rb_last <= readback_out;
    initial begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        frame_serial_in = 1'b0;
        chain_token_in = 1'b0;
        cap = 32'h0;
        tokf = 3'h0;
    end
    task automatic frame(input logic [95:0] f, input int nf, input int fsw, input int tok);
        tokf <= 3'h0;
        for (int i = 0; i < nf * 32; i++) begin
            frame_sync <= (i < fsw);
            frame_serial_in <= f[95 - i];
            chain_token_in <= (tok >= 0) && (i >= tok);
            repeat (4) @(posedge pclk);
            bit_clock <= 1'b1;
            if (i < 32) cap[31 - i] <= rb_line;
            tokf[i / 32] <= tokf[i / 32] | chain_token_out;
            repeat (4) @(posedge pclk);
            bit_clock <= 1'b0;
        end
        frame_sync <= 1'b0;
        chain_token_in <= 1'b0;
        frame_serial_in <= ~frame_serial_in;
        repeat (64) @(posedge pclk);
    endtask
endmodule // tcas_host

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tcas_pkg::*;
    typedef struct packed {logic [95:0] f; logic [1:0] nf; logic [11:0] a; logic [7:0] e;} tcas_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, bit_clock, frame_sync, frame_serial_in, chain_token_in;
    logic chain_token_out, readback_out, readback_oe_n, audio_valid, tdm_mode;
    logic [23:0] audio_left, audio_right;
    logic [31:0] cap;
    logic [2:0] tokf;
    tcas_row_t rows [6];
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int n_valid = 0;

    always #20 pclk = ~pclk;
    tcas_slave dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bit_clock, .frame_sync, .frame_serial_in, .chain_token_in,
        .chain_token_out, .readback_out, .readback_oe_n, .audio_left, .audio_right,
        .audio_valid, .tdm_mode);
    tcas_host host_u (.pclk, .bit_clock, .frame_sync, .frame_serial_in, .chain_token_in,
        .chain_token_out, .readback_out, .readback_oe_n, .cap, .tokf);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] cmd(input logic [2:0] t, input logic [4:0] id,
        input logic rw, input logic [6:0] r, input logic [7:0] d);
        return {t, id, rw, r, d, 8'h00};
    endfunction
    task automatic final_report();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (audio_valid === 1'b1) n_valid <= n_valid + 1;
        if (cyc == 30000) begin
            n_errors++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        rows[0] = '{{cmd(3'h0, 5'h03, 1'b0, 7'h10, 8'ha5), 64'h0}, 2'h1, 12'h040, 8'ha5};
        rows[1] = '{{cmd(3'h0, 5'h1f, 1'b0, 7'h11, 8'h3c), 64'h0}, 2'h1, 12'h044, 8'h3c};
        rows[2] = '{{cmd(3'h0, 5'h00, 1'b0, 7'h10, 8'h11), 64'h0}, 2'h1, 12'h040, 8'ha5};
        rows[3] = '{{cmd(3'h1, 5'h03, 1'b0, 7'h12, 8'h77), 64'h0}, 2'h1, 12'h048, 8'h00};
        rows[4] = '{{cmd(3'h0, 5'h04, 1'b0, 7'h12, 8'h55), 64'h0}, 2'h1, 12'h048, 8'h00};
        rows[5] = '{{cmd(3'h2, 5'h03, 1'b0, 7'h14, 8'h01), cmd(3'h4, 5'h03, 1'b0, 7'h15, 8'h99),
            32'h0}, 2'h2, 12'h054, 8'h99};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(12'h000, 32'h0);
        rdchk(12'h05c, 32'h0);
        host_u.frame(96'h0, 1, 2, -1);
        host_u.frame(96'h0, 1, 2, -1);
        chk(32'(tdm_mode), 32'h1);
        host_u.frame({cmd(3'h4, 5'h00, 1'b0, 7'h00, 8'h00), 64'h0}, 2, 2, 34);
        chk(32'(chain_token_out), 32'h1);
        rdchk(12'h000, 32'h63);
        rdchk(12'h05c, 32'h3);
        for (int k = 0; k < 6; k++) begin
            host_u.frame(rows[k].f, int'(rows[k].nf), 2, -1);
            rdchk(rows[k].a, 32'(rows[k].e));
        end
        host_u.frame({cmd(3'h0, 5'h03, 1'b1, 7'h10, 8'h00), 64'h0}, 1, 2, -1);
        chk(32'(cap[16:0]), 32'h0a500);
        host_u.frame({32'h0, 32'h12345600, 32'habcdef00}, 3, 2, 0);
        chk(32'(audio_left), 32'h123456);
        chk(32'(audio_right), 32'habcdef);
        chk(32'(n_valid), 32'h1);
        chk(32'(tokf[2:1]), 32'h2);
        apb(1'b1, 12'h04c, 32'h1);
        host_u.frame({32'h0, 32'h11111100, 32'h22222200}, 3, 2, 40);
        chk(32'(audio_left), 32'h123456);
        chk(32'(tokf[2:1]), 32'h3);
        chk(32'(n_valid), 32'h1);
        apb(1'b1, 12'h05c, 32'h1f);
        rdchk(12'h05c, 32'h3);
        apb(1'b1, 12'h058, 32'h5a);
        rdchk(12'h058, 32'h5a);
        rdchk(12'h100, 32'h0);
        chk(32'(er), 32'h1);
        host_u.frame(96'h0, 1, 16, -1);
        chk(32'(tdm_mode), 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(12'h040, 32'h0);
        final_report();
    end
endmodule // tb

`default_nettype wire
